// File: common/boundary_scan_pkg.sv
// Constants and types shared by the boundary scan test port.
package boundary_scan_pkg;

    // ****************************************
    // Sizes and encodings
    // ****************************************
    localparam int IO_COUNT = 8;             // Default count of user I/O cells.
    localparam int CELLS_PER_IO = 3;         // Input, output and enable cell.
    localparam int CELL_IN = 0;              // Cell position of the input capture.
    localparam int CELL_OUT = 1;             // Cell position of the output drive.
    localparam int CELL_OE = 2;              // Cell position of the enable drive.
    localparam int SYNC_STAGES = 2;          // Flip-flops on every pin input but the test reset.
    localparam int ID_WIDTH = 32;
    localparam int IR_WIDTH = 4;             // Default instruction length.
    localparam int FIFO_DEPTH = 8;
    localparam logic [1:0] IR_CAPTURE = 2'h1; // Fixed low bits loaded at capture.
    localparam logic [3:0] OP_EXTEST = 4'h0;
    localparam logic [3:0] OP_SAMPLE = 4'h1;
    localparam logic [3:0] OP_IDCODE = 4'h2;
    localparam logic [3:0] OP_BYPASS = 4'hf;
    // Identification fields; the values are arbitrary.
    localparam logic [3:0] ID_VERSION = 4'h1;
    localparam logic [15:0] ID_PART = 16'h0a5c;
    localparam logic [10:0] ID_MAKER = 11'h05a;

    // ****************************************
    // Types
    // ****************************************
    // Controller states, Gray-adjacent in the order listed.
    typedef enum logic [3:0] {
        TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h3, CAP_DR = 4'h2,
        SH_DR = 4'h6, EX1_DR = 4'h7, PAU_DR = 4'h5, EX2_DR = 4'h4,
        UPD_DR = 4'hc, SEL_IR = 4'hd, CAP_IR = 4'hf, SH_IR = 4'he,
        EX1_IR = 4'ha, PAU_IR = 4'hb, EX2_IR = 4'h9, UPD_IR = 4'h8
    } tap_state_e;

    // Test port pins travelling together through the synchroniser.
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jtag_pins_s;

endpackage : boundary_scan_pkg

// File: src/boundary_scan_tap.sv
// Boundary scan test port: word FIFO and the test access port logic.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Word FIFO
// ****************************************
// Flip-flop FIFO with valid and ready on both sides.
module bscan_word_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = boundary_scan_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = AW'(DEPTH) == '0 ? {1'b1, {AW{1'b0}}} : (AW+1)'(DEPTH);

    logic [WIDTH-1:0] store_r [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;
    wire [AW-1:0] wrNext = (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
    wire [AW-1:0] rdNext = (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;

    assign inReady = (count_r != FULL_COUNT);
    assign outValid = (count_r != '0);
    assign outData = store_r[rdPtr_r];

    // Storage is written only on a push; it needs no reset.
    always_ff @(posedge mclk) begin
        if (push) begin
            store_r[wrPtr_r] <= inData;
        end
    end

    // Pointers and fill level.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) wrPtr_r <= wrNext;
            if (pop) rdPtr_r <= rdNext;
            if (push && !pop) count_r <= count_r + 1'b1;
            else if (pop && !push) count_r <= count_r - 1'b1;
        end
    end
endmodule : bscan_word_fifo

// ****************************************
// Test access port
// ****************************************
// Behaviour
// - The controller is a sixteen-state machine held in four bits that walks the standard diagram.
// - Each move is chosen by the mode select level seen at a rising test clock edge.
// - After power-up the controller sits in Test-Logic-Reset with no tester action.
// - Five test clock rises with mode select high bring the controller to Test-Logic-Reset.
// - The test reset pin puts the controller in Test-Logic-Reset at once, without a clock.
// - The decoder knows EXTEST, SAMPLE/PRELOAD, BYPASS and IDCODE.
// - There are three data registers, bypass, identification and boundary, picked by instruction.
// - Bypass is the data path whenever no other data register is chosen.
// - The identification register shifts 32 bits: marker one, maker, part and version.
// - Every I/O has three boundary cells, each with serial and parallel in; only the output and enable cells drive a parallel out.
// - The boundary register both captures and drives every I/O pin.
// - All cells form one chain from test data in to test data out.
// - While unprogrammed the I/Os stay disabled and sampling captures nothing useful.
module boundary_scan_tap #(
    parameter int NUM_IO = boundary_scan_pkg::IO_COUNT,
    parameter int IR_LEN = boundary_scan_pkg::IR_WIDTH,
    parameter logic [IR_LEN-1:0] OPC_EXTEST = IR_LEN'(boundary_scan_pkg::OP_EXTEST),
    parameter logic [IR_LEN-1:0] OPC_SAMPLE = IR_LEN'(boundary_scan_pkg::OP_SAMPLE),
    parameter logic [IR_LEN-1:0] OPC_IDCODE = IR_LEN'(boundary_scan_pkg::OP_IDCODE),
    parameter logic [IR_LEN-1:0] OPC_BYPASS = IR_LEN'(boundary_scan_pkg::OP_BYPASS)
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trstN,
    output logic tdo,
    output logic tdoEn,
    input wire logic programmed,
    input wire logic [NUM_IO-1:0] coreOut,
    input wire logic [NUM_IO-1:0] coreOe,
    output logic [NUM_IO-1:0] coreIn,
    input wire logic [NUM_IO-1:0] padIn,
    output logic [NUM_IO-1:0] padOut,
    output logic [NUM_IO-1:0] padOe,
    input wire logic padReady
);
    localparam int BW = boundary_scan_pkg::CELLS_PER_IO * NUM_IO;
    localparam int IDW = boundary_scan_pkg::ID_WIDTH;
    localparam logic [IDW-1:0] ID_VALUE = {boundary_scan_pkg::ID_VERSION,
        boundary_scan_pkg::ID_PART, boundary_scan_pkg::ID_MAKER, 1'b1};

    // ****************************************
    // Pin synchronisers
    // ****************************************
    boundary_scan_pkg::jtag_pins_s pinMeta_r;
    boundary_scan_pkg::jtag_pins_s pinSync_r;
    logic tckLast_r;
    logic [NUM_IO-1:0] padMeta_r;
    logic [NUM_IO-1:0] padSync_r;
    logic progMeta_r;
    logic progSync_r;

    // Two flip-flops on every pin but the test reset; only the second stage is used below.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pinMeta_r <= '1;
            pinSync_r <= '1;
            tckLast_r <= 1'b1; // Idle pin levels, so leaving reset shows no false clock edge.
            padMeta_r <= '0;
            padSync_r <= '0;
            progMeta_r <= 1'b0;
            progSync_r <= 1'b0;
        end else begin
            pinMeta_r <= '{tck: tck, tms: tms, tdi: tdi};
            pinSync_r <= pinMeta_r;
            tckLast_r <= pinSync_r.tck;
            padMeta_r <= padIn;
            padSync_r <= padMeta_r;
            progMeta_r <= programmed;
            progSync_r <= progMeta_r;
        end
    end

    wire tckRise = pinSync_r.tck && !tckLast_r;
    wire tckFall = !pinSync_r.tck && tckLast_r;
    wire tmsLvl = pinSync_r.tms;
    wire tdiLvl = pinSync_r.tdi;
    wire ioEnable = progSync_r;

    // ****************************************
    // Controller
    // ****************************************
    boundary_scan_pkg::tap_state_e state_r;
    boundary_scan_pkg::tap_state_e state_nxt;

    always_comb begin
        case (state_r)
            boundary_scan_pkg::TLR: state_nxt = tmsLvl ? boundary_scan_pkg::TLR
                                                       : boundary_scan_pkg::RTI;
            boundary_scan_pkg::RTI: state_nxt = tmsLvl ? boundary_scan_pkg::SEL_DR
                                                       : boundary_scan_pkg::RTI;
            boundary_scan_pkg::SEL_DR: state_nxt = tmsLvl ? boundary_scan_pkg::SEL_IR
                                                          : boundary_scan_pkg::CAP_DR;
            boundary_scan_pkg::CAP_DR: state_nxt = tmsLvl ? boundary_scan_pkg::EX1_DR
                                                          : boundary_scan_pkg::SH_DR;
            boundary_scan_pkg::SH_DR: state_nxt = tmsLvl ? boundary_scan_pkg::EX1_DR
                                                         : boundary_scan_pkg::SH_DR;
            boundary_scan_pkg::EX1_DR: state_nxt = tmsLvl ? boundary_scan_pkg::UPD_DR
                                                          : boundary_scan_pkg::PAU_DR;
            boundary_scan_pkg::PAU_DR: state_nxt = tmsLvl ? boundary_scan_pkg::EX2_DR
                                                          : boundary_scan_pkg::PAU_DR;
            boundary_scan_pkg::EX2_DR: state_nxt = tmsLvl ? boundary_scan_pkg::UPD_DR
                                                          : boundary_scan_pkg::SH_DR;
            boundary_scan_pkg::UPD_DR: state_nxt = tmsLvl ? boundary_scan_pkg::SEL_DR
                                                          : boundary_scan_pkg::RTI;
            boundary_scan_pkg::SEL_IR: state_nxt = tmsLvl ? boundary_scan_pkg::TLR
                                                          : boundary_scan_pkg::CAP_IR;
            boundary_scan_pkg::CAP_IR: state_nxt = tmsLvl ? boundary_scan_pkg::EX1_IR
                                                          : boundary_scan_pkg::SH_IR;
            boundary_scan_pkg::SH_IR: state_nxt = tmsLvl ? boundary_scan_pkg::EX1_IR
                                                         : boundary_scan_pkg::SH_IR;
            boundary_scan_pkg::EX1_IR: state_nxt = tmsLvl ? boundary_scan_pkg::UPD_IR
                                                          : boundary_scan_pkg::PAU_IR;
            boundary_scan_pkg::PAU_IR: state_nxt = tmsLvl ? boundary_scan_pkg::EX2_IR
                                                          : boundary_scan_pkg::PAU_IR;
            boundary_scan_pkg::EX2_IR: state_nxt = tmsLvl ? boundary_scan_pkg::UPD_IR
                                                          : boundary_scan_pkg::SH_IR;
            boundary_scan_pkg::UPD_IR: state_nxt = tmsLvl ? boundary_scan_pkg::SEL_DR
                                                          : boundary_scan_pkg::RTI;
            default: state_nxt = boundary_scan_pkg::TLR;
        endcase
    end

    // asynchronous test reset
    // The test reset pin clears the controller without waiting for any clock.
    always_ff @(posedge mclk or posedge rst or negedge trstN) begin
        if (rst || !trstN) begin
            state_r <= boundary_scan_pkg::TLR;
        end else if (tckRise) begin
            state_r <= state_nxt;
        end
    end

    wire inTlr = (state_r == boundary_scan_pkg::TLR);
    wire capDr = tckRise && (state_r == boundary_scan_pkg::CAP_DR);
    wire shDr = tckRise && (state_r == boundary_scan_pkg::SH_DR);
    wire capIr = tckRise && (state_r == boundary_scan_pkg::CAP_IR);
    wire shIr = tckRise && (state_r == boundary_scan_pkg::SH_IR);
    wire updDr = tckFall && (state_r == boundary_scan_pkg::UPD_DR);
    wire updIr = tckFall && (state_r == boundary_scan_pkg::UPD_IR);

    // ****************************************
    // Instruction register and decode
    // ****************************************
    logic [IR_LEN-1:0] irShift_r;
    logic [IR_LEN-1:0] irHold_r;

    // The held instruction falls back to IDCODE whenever the controller resets.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irShift_r <= '0;
            irHold_r <= OPC_IDCODE;
        end else begin
            if (capIr) irShift_r <= {{(IR_LEN-2){1'b0}}, boundary_scan_pkg::IR_CAPTURE};
            else if (shIr) irShift_r <= {tdiLvl, irShift_r[IR_LEN-1:1]};
            if (inTlr) irHold_r <= OPC_IDCODE;
            else if (updIr) irHold_r <= irShift_r;
        end
    end

    wire selExtest = (irHold_r == OPC_EXTEST);
    wire selSample = (irHold_r == OPC_SAMPLE);
    wire selId = (irHold_r == OPC_IDCODE);
    wire selBound = selExtest || selSample;
    wire selBypass = !selBound && !selId;

    // ****************************************
    // Data registers
    // ****************************************
    logic bypass_r;
    logic [IDW-1:0] idShift_r;
    logic [BW-1:0] bsShift_r;
    logic [BW-1:0] bsHold_r;
    logic [BW-1:0] bsCapture;

    // capture from the pins
    // An unprogrammed part keeps input buffers off, so the input cells read zero.
    for (genvar i = 0; i < NUM_IO; i++) begin : g_cell
        assign bsCapture[boundary_scan_pkg::CELLS_PER_IO*i + boundary_scan_pkg::CELL_IN] =
            padSync_r[i] && ioEnable;
        assign bsCapture[boundary_scan_pkg::CELLS_PER_IO*i + boundary_scan_pkg::CELL_OUT] =
            coreOut[i];
        assign bsCapture[boundary_scan_pkg::CELLS_PER_IO*i + boundary_scan_pkg::CELL_OE] =
            coreOe[i] && ioEnable;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bypass_r <= 1'b0;
            idShift_r <= '0;
            bsShift_r <= '0;
        end else begin
            if (capDr) bypass_r <= 1'b0;
            else if (shDr) bypass_r <= tdiLvl;
            if (capDr && selId) idShift_r <= ID_VALUE;
            else if (shDr && selId) idShift_r <= {tdiLvl, idShift_r[IDW-1:1]};
            if (capDr && selBound) bsShift_r <= bsCapture;
            else if (shDr && selBound) bsShift_r <= {tdiLvl, bsShift_r[BW-1:1]};
        end
    end

    wire drOut = selBound ? bsShift_r[0] : (selId ? idShift_r[0] : bypass_r);
    wire inShDr = (state_r == boundary_scan_pkg::SH_DR);
    wire inShIr = (state_r == boundary_scan_pkg::SH_IR);

    // falling-edge output
    // Both output and enable move together on the falling edge, the same edge
    // that a downstream part will not sample on.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tdo <= 1'b0;
            tdoEn <= 1'b0;
        end else if (tckFall) begin
            tdo <= inShIr ? irShift_r[0] : (inShDr && drOut); // Low while released.
            tdoEn <= inShIr || inShDr;
        end
    end

    // ****************************************
    // Update path through the FIFO
    // ****************************************
    logic updPend_r;
    logic fifoInReady;
    logic fifoOutValid;
    logic [BW-1:0] fifoOutData;

    // An update waits here while the FIFO is full; a second update in that time overwrites the waiting one.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            updPend_r <= 1'b0;
            bsHold_r <= '0;
        end else if (updDr && selBound) begin
            updPend_r <= 1'b1;
            bsHold_r <= bsShift_r;
        end else if (fifoInReady) begin
            updPend_r <= 1'b0;
        end
    end

    bscan_word_fifo #(
        .WIDTH(BW),
        .DEPTH(boundary_scan_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .inValid(updPend_r),
        .inReady(fifoInReady),
        .inData(bsHold_r),
        .outValid(fifoOutValid),
        .outReady(padReady),
        .outData(fifoOutData)
    );

    // ****************************************
    // Pad drive
    // ****************************************
    logic [NUM_IO-1:0] extOut_r;
    logic [NUM_IO-1:0] extOe_r;
    logic [NUM_IO-1:0] fifoOut;
    logic [NUM_IO-1:0] fifoOe;

    for (genvar i = 0; i < NUM_IO; i++) begin : g_pad
        assign fifoOut[i] =
            fifoOutData[boundary_scan_pkg::CELLS_PER_IO*i + boundary_scan_pkg::CELL_OUT];
        assign fifoOe[i] =
            fifoOutData[boundary_scan_pkg::CELLS_PER_IO*i + boundary_scan_pkg::CELL_OE];
    end

    // drive the pins
    // Under EXTEST the pads follow the last word taken from the FIFO; otherwise
    // the core drives them. keeps every enable off while unprogrammed.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            extOut_r <= '0;
            extOe_r <= '0;
            padOut <= '0;
            padOe <= '0;
            coreIn <= '0;
        end else begin
            if (fifoOutValid && padReady) begin
                extOut_r <= fifoOut;
                extOe_r <= fifoOe;
            end
            padOut <= selExtest ? extOut_r : coreOut;
            padOe <= (selExtest ? extOe_r : coreOe) & {NUM_IO{ioEnable}};
            coreIn <= padSync_r & {NUM_IO{ioEnable}};
        end
    end
endmodule : boundary_scan_tap

`default_nettype wire

// File: dv/jtag_tester_model.sv
// Behavioural external test controller that drives the scan pins.
`timescale 1ns/1ps
`default_nettype none
module jtag_tester_model (
    input wire logic mclk,
    input wire logic tdo,
    input wire logic tdoEn,
    output logic tck,
    output logic tms,
    output logic tdi
);
    logic tdoSeen;
    logic enSeen;
    // Pins idle high; the clock stands still between transfers.
    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b1;
        tdoSeen = 1'b1;
        enSeen = 1'b0;
    end
    // setup before rise
    // One 80 ns period; tdo is read late in the high phase, well after the fall.
    // The line has a pull-up, so a released output reads as one.
    task automatic tick(input logic m, input logic d);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge mclk);
        tck <= 1'b1;
        repeat (4) @(posedge mclk);
        tdoSeen = tdoEn ? tdo : 1'b1;
        enSeen = tdoEn;
    endtask : tick
    task automatic tmsReset;
        repeat (5) tick(1'b1, 1'b0);
    endtask : tmsReset
endmodule : jtag_tester_model
`default_nettype wire

// File: dv/boundary_scan_checker.sv
// Concurrent checks on the scan port pins and pad outputs.
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_checker #(
    parameter int NUM_IO = boundary_scan_pkg::IO_COUNT
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trstN,
    input wire logic tdo,
    input wire logic tdoEn,
    input wire logic programmed,
    input wire logic [NUM_IO-1:0] coreOut,
    input wire logic [NUM_IO-1:0] coreOe,
    input wire logic [NUM_IO-1:0] coreIn,
    input wire logic [NUM_IO-1:0] padIn,
    input wire logic [NUM_IO-1:0] padOut,
    input wire logic [NUM_IO-1:0] padOe,
    input wire logic padReady
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic tckPrev_r;
    logic [2:0] ones_r;
    logic [2:0] ones_nxt;
    logic tckRise;
    // Counts successive clock rises with mode select high, clearing on a rise with it low; saturates so it never wraps.
    assign tckRise = tck && !tckPrev_r;
    assign ones_nxt = !tckRise ? ones_r : (!tms ? 3'h0 : ones_r + 3'(ones_r != 3'h7));
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tckPrev_r <= 1'b1;
            ones_r <= 3'h0;
        end else begin
            tckPrev_r <= tck;
            ones_r <= ones_nxt;
        end
    end
    property p_reset_quiet;
        disable iff (1'b0) rst |-> !tdoEn && !tdo && padOe == '0 && padOut == '0 && coreIn == '0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("Output active in reset.");
    property p_after_fall;
        ($changed(tdo) || $changed(tdoEn)) |-> !$past(tck) && !$past(tck, 2);
    endproperty
    a_after_fall: assert property (p_after_fall) else $error("Serial out moved off a fall.");
    property p_idle_low;
        !tdoEn |-> !tdo;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("Serial out high while released.");
    property p_oe_unprog;
        !programmed [*4] |=> padOe == '0;
    endproperty
    a_oe_unprog: assert property (p_oe_unprog) else $error("Pad enabled while blank.");
    property p_in_unprog;
        !programmed [*4] |=> coreIn == '0;
    endproperty
    a_in_unprog: assert property (p_in_unprog) else $error("Input passed while blank.");
    property p_in_path;
        (programmed && $stable(padIn)) [*5] |=> coreIn == $past(padIn);
    endproperty
    a_in_path: assert property (p_in_path) else $error("Core input lost pad level.");
    property p_oe_prog;
        (|padOe) |-> $past(programmed, 2) || $past(programmed, 3);
    endproperty
    a_oe_prog: assert property (p_oe_prog) else $error("Pad enabled without program.");
    property p_five_ones;
        ones_r >= 3'h5 |-> !tdoEn;
    endproperty
    a_five_ones: assert property (p_five_ones) else $error("Shifting after five ones.");
endmodule : boundary_scan_checker
bind boundary_scan_tap boundary_scan_checker #(.NUM_IO(NUM_IO)) chk (
    .mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN),
    .tdo(tdo), .tdoEn(tdoEn), .programmed(programmed), .coreOut(coreOut),
    .coreOe(coreOe), .coreIn(coreIn), .padIn(padIn), .padOut(padOut),
    .padOe(padOe), .padReady(padReady)
);
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the boundary scan test port.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int N = boundary_scan_pkg::IO_COUNT;
    localparam logic [31:0] ID_WORD = {boundary_scan_pkg::ID_VERSION,
        boundary_scan_pkg::ID_PART, boundary_scan_pkg::ID_MAKER, 1'b1};
    logic mclk;
    logic rst;
    logic trstN;
    logic programmed;
    logic padReady;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdoEn;
    logic [N-1:0] coreOut;
    logic [N-1:0] coreOe;
    logic [N-1:0] coreIn;
    logic [N-1:0] padIn;
    logic [N-1:0] padOut;
    logic [N-1:0] padOe;
    logic [31:0] got;
    int fails;
    int n_checks;
    boundary_scan_tap #(.NUM_IO(N)) dut (
        .mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN),
        .tdo(tdo), .tdoEn(tdoEn), .programmed(programmed), .coreOut(coreOut),
        .coreOe(coreOe), .coreIn(coreIn), .padIn(padIn), .padOut(padOut),
        .padOe(padOe), .padReady(padReady)
    );
    jtag_tester_model tester (
        .mclk(mclk), .tdo(tdo), .tdoEn(tdoEn), .tck(tck), .tms(tms), .tdi(tdi)
    );
    // ****************************************
    // Helpers
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step(input logic m);
        tester.tick(m, 1'b0);
    endtask : step
    // One scan from idle back to idle; the last bit leaves with mode select high.
    task automatic scan(input logic ir, input int n, input logic [31:0] din);
        got = '0;
        step(1'b0);
        step(1'b1);
        if (ir) begin
            step(1'b1);
        end
        step(1'b0);
        step(1'b0);
        for (int i = 0; i < n; i++) begin
            tester.tick(1'(i == n - 1), din[i]);
            got[i] = tester.tdoSeen;
            check("tdoEn shift", 32'(tester.enSeen), 32'h1);
        end
        step(1'b1);
        check("tdoEn idle", 32'(tester.enSeen), 32'h0);
        step(1'b0);
    endtask : scan
    task automatic loadOp(input logic [3:0] op);
        scan(1'b1, 4, {28'h0, op});
        check("ir capture", 32'(got[1:0]), 32'(boundary_scan_pkg::IR_CAPTURE));
    endtask : loadOp
    // ****************************************
    // Scenarios
    // ****************************************
    // identity word
    task automatic idRead(input string what);
        scan(1'b0, 32, 32'h0);
        check(what, got, ID_WORD);
    endtask : idRead
    task automatic bypassRun;
        logic [3:0] ops [2] = '{boundary_scan_pkg::OP_BYPASS, 4'h7};
        foreach (ops[k]) begin
            loadOp(ops[k]);
            scan(1'b0, 8, 32'hb4);
            check("bypass", got, 32'h68);
        end
    endtask : bypassRun
    task automatic extestRun;
        logic [31:0] w = '0;
        for (int i = 0; i < N; i++) begin
            w[3*i+1] = 1'(8'ha5 >> i);
            w[3*i+2] = 1'(8'h3c >> i);
        end
        loadOp(boundary_scan_pkg::OP_EXTEST);
        padReady <= 1'b0;
        scan(1'b0, 3 * N, w);
        check("pads stalled", 32'(padOut), 32'h0);
        padReady <= 1'b1;
        repeat (8) @(posedge mclk);
        check("padOut", 32'(padOut), 32'ha5);
        check("padOe", 32'(padOe), 32'h3c);
    endtask : extestRun
    task automatic sampleRun(input logic prog);
        logic [7:0] inBits;
        programmed <= prog;
        padIn <= 8'h96;
        repeat (6) @(posedge mclk);
        loadOp(boundary_scan_pkg::OP_SAMPLE);
        scan(1'b0, 32, 32'hc3);
        for (int i = 0; i < N; i++) begin
            inBits[i] = got[3*i];
        end
        check("captured inputs", 32'(inBits), prog ? 32'h96 : 32'h0);
        check("chain tail", 32'(got[31:24]), 32'hc3);
        check("padOe", 32'(padOe), prog ? 32'(coreOe) : 32'h0);
        check("coreIn", 32'(coreIn), prog ? 32'h96 : 32'h0);
    endtask : sampleRun
    task automatic resetRuns;
        loadOp(boundary_scan_pkg::OP_BYPASS);
        step(1'b1);
        step(1'b0);
        step(1'b0);
        tester.tmsReset();
        idRead("id after ones");
        loadOp(boundary_scan_pkg::OP_BYPASS);
        step(1'b1);
        step(1'b1);
        trstN <= 1'b0;
        repeat (4) @(posedge mclk);
        trstN <= 1'b1;
        repeat (2) @(posedge mclk);
        idRead("id after trst");
    endtask : resetRuns
    task automatic report_and_stop;
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    // Reset for two cycles, then every scenario in turn.
    initial begin
        fails = 0;
        n_checks = 0;
        rst = 1'b0;
        trstN = 1'b1;
        programmed = 1'b1;
        padReady = 1'b1;
        coreOut = 8'h5a;
        coreOe = 8'hf0;
        padIn = 8'h00;
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
        idRead("id after reset");
        bypassRun();
        extestRun();
        sampleRun(1'b1);
        sampleRun(1'b0);
        resetRuns();
        report_and_stop();
    end
    // The scans need about 27 us; a hang is cut well after that.
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
